/* hw/adc_sequencer_control.sv */
// adc sequencer control: registers, conversion sequence, port map
// assumes a successive-approximation comparator outside; avalon-mm slave
`timescale 1ns/1ps
module adc_sequencer_control (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // analog front end
  output logic [2:0] channel_sel,
  output logic sample_connect,
  output logic converter_powered,
  output logic sar_trial_valid,
  output logic [9:0] sar_trial,
  input wire logic comparator_high,
  output adc_seq_pkg::port_map_t port_map,
  // system side
  input wire logic sleep_mode,
  input wire logic special_trigger,
  input wire logic [7:0] port_pins_in,
  output logic [7:0] port_read_data,
  output logic converter_irq
);
  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_GAP} seq_state_t;
  seq_state_t state_reg;
  logic [7:0] main_reg;
  logic [7:0] cfg_reg;
  logic [7:0] res_hi_reg;
  logic [7:0] res_lo_reg;
  logic irq_flag_reg;
  logic irq_en_reg;
  logic [3:0] tad_cnt_reg;
  logic [9:0] sar_reg;
  logic [31:0] rdata_reg;
  logic ack_reg;
  logic req;
  logic wr_hit;
  logic tad_tick;
  logic power_on;
  logic rc_sel;
  logic clk_run;
  logic go_write_one;
  logic go_write_zero;
  logic start_conv;
  logic done_conv;
  logic abort_conv;
  logic [9:0] trial_bit;
  logic [15:0] result_packed;

  assign req = avs_read || avs_write;
  assign avs_waitrequest = req && !ack_reg;
  assign wr_hit = avs_write && ack_reg && avs_byteenable[0];
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req && !ack_reg;
    end
  end

  assign power_on = main_reg[adc_seq_pkg::POS_POWER];
  assign rc_sel = (main_reg[7:6] == 2'h3);
  // sleep halts the oscillator divider; only the rc clock keeps ticking
  assign clk_run = power_on && (state_reg != ST_IDLE) && (!sleep_mode || rc_sel);
  assign go_write_one = wr_hit && (avs_address == adc_seq_pkg::OFF_MAIN)
      && avs_writedata[adc_seq_pkg::POS_GO];
  assign go_write_zero = wr_hit && (avs_address == adc_seq_pkg::OFF_MAIN)
      && !avs_writedata[adc_seq_pkg::POS_GO];
  assign start_conv = (state_reg == ST_IDLE) && power_on
      && (go_write_one || special_trigger);
  assign abort_conv = (state_reg == ST_CONV) && (go_write_zero || !power_on);
  assign done_conv = (state_reg == ST_CONV) && tad_tick && !abort_conv
      && (tad_cnt_reg == 4'(adc_seq_pkg::CONV_PERIODS - 1));

  adc_tad_divider #(
    .RC_DIV(adc_seq_pkg::RC_DIV)
  ) u_div (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .run(clk_run),
    .clock_sel({cfg_reg[6], main_reg[7:6]}),
    .tad_tick(tad_tick)
  );

  // main control register; go is owned by the sequencer below
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      main_reg <= adc_seq_pkg::MAIN_RESET;
    end else begin
      if (wr_hit && avs_address == adc_seq_pkg::OFF_MAIN) begin
        main_reg[7:3] <= avs_writedata[7:3];
        main_reg[0] <= avs_writedata[0];
      end
      main_reg[1] <= 1'b0;
      if (start_conv) begin
        main_reg[adc_seq_pkg::POS_GO] <= 1'b1;
      end else if (done_conv || abort_conv || state_reg != ST_CONV) begin
        main_reg[adc_seq_pkg::POS_GO] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cfg_reg <= adc_seq_pkg::CFG_RESET;
    end else if (wr_hit && avs_address == adc_seq_pkg::OFF_CFG) begin
      cfg_reg <= avs_writedata[7:0] & adc_seq_pkg::CFG_WMASK;
    end
  end

  // sequencer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      tad_cnt_reg <= 4'h0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          tad_cnt_reg <= 4'h0;
          if (start_conv) begin
            state_reg <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (abort_conv || done_conv) begin
            state_reg <= ST_GAP;
            tad_cnt_reg <= 4'h0;
          end else if (tad_tick) begin
            tad_cnt_reg <= tad_cnt_reg + 4'h1;
          end
        end
        ST_GAP: begin
          if (!power_on) begin
            state_reg <= ST_IDLE;
          end else if (tad_tick) begin
            if (tad_cnt_reg == 4'(adc_seq_pkg::GAP_PERIODS - 1)) begin
              state_reg <= ST_IDLE;
            end
            tad_cnt_reg <= tad_cnt_reg + 4'h1;
          end
        end
      endcase
    end
  end

  // successive approximation: bits 9..0 on periods 1..10 of the twelve
  always_comb begin
    trial_bit = 10'h000;
    if (tad_cnt_reg >= 4'h1 && tad_cnt_reg <= 4'hA) begin
      trial_bit = 10'h200 >> (tad_cnt_reg - 4'h1);
    end
  end
  always_ff @(posedge ref_clk) begin
    if (start_conv) begin
      sar_reg <= 10'h000;
    end else if (state_reg == ST_CONV && tad_tick && trial_bit != 10'h000) begin
      sar_reg <= comparator_high ? (sar_reg | trial_bit) : sar_reg;
    end
  end
  assign sar_trial = sar_reg | trial_bit;
  assign sar_trial_valid = (state_reg == ST_CONV) && (trial_bit != 10'h000);

  always_comb begin
    if (cfg_reg[adc_seq_pkg::POS_JUSTIFY]) begin
      result_packed = {6'h00, sar_reg};
    end else begin
      result_packed = {sar_reg, 6'h00};
    end
  end
  // no reset: contents survive reset and are unknown after power-up
  always_ff @(posedge ref_clk) begin
    if (done_conv) begin
      res_hi_reg <= result_packed[15:8];
      res_lo_reg <= result_packed[7:0];
    end else if (wr_hit && avs_address == adc_seq_pkg::OFF_RES_HI) begin
      res_hi_reg <= avs_writedata[7:0];
    end else if (wr_hit && avs_address == adc_seq_pkg::OFF_RES_LO) begin
      res_lo_reg <= avs_writedata[7:0];
    end
  end

  // irq flag and enable ride in the main register, above its low byte
  logic irq_wr;
  assign irq_wr = wr_hit && (avs_address == adc_seq_pkg::OFF_MAIN) && avs_writedata[8];
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_flag_reg <= 1'b0;
      irq_en_reg <= 1'b0;
    end else begin
      if (irq_wr) begin
        irq_en_reg <= avs_writedata[9];
      end
      if (done_conv) begin
        irq_flag_reg <= 1'b1;
      end else if (irq_wr && !avs_writedata[10]) begin
        irq_flag_reg <= 1'b0;
      end
    end
  end
  assign converter_irq = irq_flag_reg && irq_en_reg;

  // port map decode
  always_comb begin
    port_map = '0;
    unique case (cfg_reg[3:0])
      4'h0: port_map = '{8'hFF, 1'b0, 1'b0};
      4'h1: port_map = '{8'hF7, 1'b1, 1'b0};
      4'h2: port_map = '{8'h1F, 1'b0, 1'b0};
      4'h3: port_map = '{8'h17, 1'b1, 1'b0};
      4'h4: port_map = '{8'h0B, 1'b0, 1'b0};
      4'h5: port_map = '{8'h03, 1'b1, 1'b0};
      4'h6, 4'h7: port_map = '{8'h00, 1'b0, 1'b0};
      4'h8: port_map = '{8'hF3, 1'b1, 1'b1};
      4'h9: port_map = '{8'h3F, 1'b0, 1'b0};
      4'hA: port_map = '{8'h37, 1'b1, 1'b0};
      4'hB: port_map = '{8'h33, 1'b1, 1'b1};
      4'hC: port_map = '{8'h13, 1'b1, 1'b1};
      4'hD: port_map = '{8'h03, 1'b1, 1'b1};
      4'hE: port_map = '{8'h01, 1'b0, 1'b0};
      4'hF: port_map = '{8'h01, 1'b1, 1'b1};
    endcase
  end
  assign port_read_data = port_pins_in & ~port_map.pin_analog;

  assign channel_sel = main_reg[5:3];
  // sampling reopens only when idle, so the gap keeps the capacitor held too
  assign sample_connect = power_on && (state_reg == ST_IDLE);
  assign converter_powered = power_on;

  // read data
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (avs_read && !ack_reg) begin
      unique case (avs_address)
        adc_seq_pkg::OFF_MAIN: rdata_reg <= {21'h0, 1'b0,
            irq_en_reg, irq_flag_reg, main_reg & adc_seq_pkg::MAIN_WMASK};
        adc_seq_pkg::OFF_CFG: rdata_reg <= {24'h0, cfg_reg};
        adc_seq_pkg::OFF_RES_HI: rdata_reg <= {24'h0, res_hi_reg};
        adc_seq_pkg::OFF_RES_LO: rdata_reg <= {24'h0, res_lo_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end
  assign avs_readdata = rdata_reg;

  chk_done_clears: assert property (@(posedge ref_clk) disable iff (sys_rst)
      done_conv |=> !main_reg[adc_seq_pkg::POS_GO] && irq_flag_reg)
    else $error("completion did not clear go and set flag");
  chk_off_nostart: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !power_on |=> state_reg != ST_CONV)
    else $error("conversion ran while off");
  chk_gap_after: assert property (@(posedge ref_clk) disable iff (sys_rst)
      state_reg == ST_GAP |-> !sample_connect && !start_conv)
    else $error("sampling or restart inside gap");
  chk_hold_open: assert property (@(posedge ref_clk) disable iff (sys_rst)
      state_reg == ST_CONV |-> !sample_connect)
    else $error("sample switch closed during conversion");
  chk_flag_sticky: assert property (@(posedge ref_clk) disable iff (sys_rst)
      irq_flag_reg && !(irq_wr && !avs_writedata[10]) |=> irq_flag_reg)
    else $error("flag dropped without a clear");
  chk_analog_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (port_read_data & port_map.pin_analog) == 8'h00)
    else $error("analog pin read nonzero");
  chk_abort_keep: assert property (@(posedge ref_clk) disable iff (sys_rst)
      abort_conv |=> $stable(res_hi_reg) && $stable(res_lo_reg))
    else $error("abort changed result");
  chk_go_start: assert property (@(posedge ref_clk) disable iff (sys_rst)
      start_conv |=> state_reg == ST_CONV && main_reg[adc_seq_pkg::POS_GO])
    else $error("start did not begin conversion");
  chk_sleep_stall: assert property (@(posedge ref_clk) disable iff (sys_rst)
      sleep_mode && !rc_sel |-> !tad_tick)
    else $error("oscillator clock ticked in sleep");
  chk_reset_analog: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $past(sys_rst) |-> port_map.pin_analog == 8'hFF)
    else $error("pins not analog after reset");
  chk_unimpl_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
      main_reg[1] == 1'b0 && cfg_reg[5:4] == 2'h0)
    else $error("unimplemented bit set");
  chk_right_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
      done_conv && cfg_reg[adc_seq_pkg::POS_JUSTIFY] |=> res_hi_reg[7:2] == 6'h00)
    else $error("right justified high bits not zero");
  chk_left_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
      done_conv && !cfg_reg[adc_seq_pkg::POS_JUSTIFY] |=> res_lo_reg[5:0] == 6'h00)
    else $error("left justified low bits not zero");
  chk_off_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !power_on |-> !sample_connect ##1 !sar_trial_valid)
    else $error("converter active while off");
  chk_go_busy: assert property (@(posedge ref_clk) disable iff (sys_rst)
      state_reg == ST_CONV |-> main_reg[adc_seq_pkg::POS_GO])
    else $error("go low during conversion");
  chk_trig_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
      special_trigger && !power_on && state_reg == ST_IDLE |=> state_reg == ST_IDLE)
    else $error("trigger started while off");
  chk_abort_gap: assert property (@(posedge ref_clk) disable iff (sys_rst)
      abort_conv |=> state_reg == ST_GAP && !main_reg[adc_seq_pkg::POS_GO])
    else $error("abort did not enter gap");
  cov_done: cover property (@(posedge ref_clk) done_conv);
  cov_abort: cover property (@(posedge ref_clk) abort_conv);
  cov_trigger: cover property (@(posedge ref_clk) special_trigger && start_conv);
  cov_sleep_rc: cover property (@(posedge ref_clk) sleep_mode && rc_sel && done_conv);
  cov_sleep_stall: cover property (@(posedge ref_clk)
      sleep_mode && !rc_sel && state_reg == ST_CONV);
endmodule

/* hw/adc_seq_pkg.sv */
// package: register map, field positions, reset values and timing counts
// assumes a 32-bit avalon-mm slave with word-aligned registers
package adc_seq_pkg;
  localparam logic [3:0] OFF_MAIN = 4'h0;
  localparam logic [3:0] OFF_CFG = 4'h4;
  localparam logic [3:0] OFF_RES_HI = 4'h8;
  localparam logic [3:0] OFF_RES_LO = 4'hC;
  localparam logic [7:0] MAIN_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] MAIN_WMASK = 8'hFD;
  localparam logic [7:0] CFG_WMASK = 8'hCF;
  localparam int POS_POWER = 0;
  localparam int POS_GO = 2;
  localparam int POS_CHAN = 3;
  localparam int POS_CLK_LO = 6;
  localparam int POS_CLK_HI = 6;
  localparam int POS_JUSTIFY = 7;
  localparam int POS_IRQ_FLAG = 0;
  localparam int POS_IRQ_EN = 1;
  localparam logic [3:0] PCFG_ALL_ANALOG = 4'h0;
  localparam logic [3:0] PCFG_DUAL_REF = 4'h8;
  localparam int CONV_PERIODS = 12;
  localparam int GAP_PERIODS = 2;
  localparam int RC_DIV = 64;
  localparam int RESULT_BITS = 10;
  typedef struct packed {
    logic [7:0] pin_analog;
    logic vref_pos_ext;
    logic vref_neg_ext;
  } port_map_t;
endpackage

/* hw/adc_tad_divider.sv */
// conversion clock divider: one-cycle pulse per bit conversion period
// assumes ref_clk is the oscillator; rc option is a fixed divide
`timescale 1ns/1ps
module adc_tad_divider #(
  parameter int RC_DIV = 64
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // control
  input wire logic run,
  input wire logic [2:0] clock_sel,
  // output
  output logic tad_tick
);
  logic [6:0] count_reg;
  logic [6:0] limit;
  always_comb begin
    unique case (clock_sel)
      3'h0: limit = 7'h01;
      3'h1: limit = 7'h07;
      3'h2: limit = 7'h1F;
      3'h4: limit = 7'h03;
      3'h5: limit = 7'h0F;
      3'h6: limit = 7'h3F;
      default: limit = 7'(RC_DIV - 1);
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !run) begin
      count_reg <= 7'h00;
    end else if (count_reg >= limit) begin
      count_reg <= 7'h00;
    end else begin
      count_reg <= count_reg + 7'h01;
    end
  end
  assign tad_tick = run && (count_reg >= limit);
endmodule

/* verif/adc_analog_model.sv */
// far side model: per-channel levels, holding capacitor, comparator
// assumes levels holds eight 10-bit words, channel 0 in the low bits
`timescale 1ns/1ps
module adc_analog_model (
  // clock
  input wire logic ref_clk,
  // from the converter
  input wire logic [2:0] channel_sel,
  input wire logic sample_connect,
  input wire logic sar_trial_valid,
  input wire logic [9:0] sar_trial,
  // from the bench
  input wire logic [79:0] levels,
  // to the converter
  output logic comparator_high
);
  logic [9:0] held;
  logic junk = 1'b0;
  // the capacitor follows the pin only while connected
  always_ff @(posedge ref_clk) begin
    if (sample_connect) begin
      held <= levels[channel_sel*10 +: 10];
    end
    junk <= ~junk;
  end
  // outside trial periods the answer means nothing, so it toggles
  assign comparator_high = sar_trial_valid ? (held >= sar_trial) : junk;
endmodule

/* verif/tb_adc_sequencer_control.sv */
// testbench: bus master, result model, port map table
// assumes a waitrequest-paced bus, registers in the low byte
`timescale 1ns/1ps
module tb_adc_sequencer_control;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [2:0] channel_sel;
  logic sample_connect;
  logic converter_powered;
  logic sar_trial_valid;
  logic [9:0] sar_trial;
  logic comparator_high;
  adc_seq_pkg::port_map_t port_map;
  logic sleep_mode = 1'b0;
  logic special_trigger = 1'b0;
  logic [7:0] port_pins_in = 8'h00;
  logic [7:0] port_read_data;
  logic converter_irq;
  logic [79:0] levels = 80'h0;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  logic [31:0] q;
  logic [31:0] kept;
  logic [7:0] hi_exp;
  logic [7:0] lo_exp;
  // analog pins per port code, bit n for channel n
  logic [7:0] an_tab [16] = '{8'hFF, 8'hF7, 8'h1F, 8'h17, 8'h0B, 8'h03, 8'h00, 8'h00,
    8'hF3, 8'h3F, 8'h37, 8'h33, 8'h13, 8'h03, 8'h01, 8'h01};
  logic [15:0] vpos_tab = 16'hBD2A;
  logic [15:0] vneg_tab = 16'hB900;

  adc_sequencer_control dut_u (.ref_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .channel_sel,
    .sample_connect, .converter_powered, .sar_trial_valid, .sar_trial, .comparator_high,
    .port_map, .sleep_mode, .special_trigger, .port_pins_in, .port_read_data, .converter_irq);
  adc_analog_model far_u (.ref_clk, .channel_sel, .sample_connect, .sar_trial_valid,
    .sar_trial, .levels, .comparator_high);

  initial forever #4 ref_clk = ~ref_clk;

  task end_of_test;
    if (err_total == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // holds the request until waitrequest is seen low at a rising edge
  task bus(input logic we, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= we;
    avs_read <= ~we;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge ref_clk);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask

  task rd_chk(input string nm, input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(nm, q, exp);
  endtask

  task conv(input logic [2:0] code, input logic just, input logic [2:0] ch, input logic slp);
    int r;
    int n;
    logic [9:0] v;
    // the ideal comparator settles at once, so any divider counts as slow enough
    r = (code[1:0] == 2'b11) ? adc_seq_pkg::RC_DIV : 2 << (2 * code[1:0] + code[2]);
    v = levels[ch*10 +: 10];
    sleep_mode <= slp;
    bus(1'b1, 4'h4, {24'h0, just, code[2], 6'h00});
    bus(1'b1, 4'h0, {21'h0, 3'b011, code[1:0], ch, 3'b001});
    repeat (20) @(posedge ref_clk);
    bus(1'b1, 4'h0, {21'h0, 3'b011, code[1:0], ch, 3'b101});
    levels[ch*10 +: 10] <= 10'($urandom);
    n = 0;
    @(negedge ref_clk);
    while (converter_irq !== 1'b1 && n < 1000) begin
      @(negedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    check("duration", 32'(n >= 12 * r - 2 && n <= 12 * r), 32'h1);
    check("channel", 32'(channel_sel), 32'(ch));
    hi_exp = just ? {6'h00, v[9:8]} : v[9:2];
    lo_exp = just ? v[7:0] : {v[1:0], 6'h00};
    rd_chk("res_hi", 4'h8, {24'h0, hi_exp});
    rd_chk("res_lo", 4'hC, {24'h0, lo_exp});
    rd_chk("main", 4'h0, {21'h0, 3'b011, code[1:0], ch, 3'b001});
    bus(1'b1, 4'h0, {21'h0, 3'b001, code[1:0], ch, 3'b001});
    check("irq_clear", 32'(converter_irq), 32'h0);
    repeat (3 * r) @(posedge ref_clk);
    check("reacquire", 32'(sample_connect), 32'h1);
    sleep_mode <= 1'b0;
  endtask

  // flag is set only when powered, and no request leaves while the enable is low
  task trig(input logic pwr);
    bus(1'b1, 4'h0, {23'h1, 8'h00, pwr});
    repeat (20) @(posedge ref_clk);
    special_trigger <= 1'b1;
    @(posedge ref_clk);
    special_trigger <= 1'b0;
    repeat (40) @(posedge ref_clk);
    rd_chk("trigger", 4'h0, {23'h0, pwr, 7'h00, pwr});
    check("trig_irq", 32'(converter_irq), 32'h0);
  endtask

  initial begin
    q = $urandom(84623);
    levels <= 80'({$urandom, $urandom, $urandom});
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    rd_chk("main_rst", 4'h0, 32'h0);
    rd_chk("cfg_rst", 4'h4, 32'h0);
    check("pins_rst", 32'(port_map), 32'h3FC);
    bus(1'b1, 4'h0, 32'hFE);
    rd_chk("main_bits", 4'h0, 32'hF8);
    check("powered", 32'(converter_powered), 32'h0);
    bus(1'b1, 4'h4, 32'hFF);
    rd_chk("cfg_bits", 4'h4, 32'hCF);
    rd_chk("unmapped", 4'h6, 32'h0);
    avs_byteenable <= 4'hE;
    bus(1'b1, 4'h4, 32'h0);
    rd_chk("lane", 4'h4, 32'hCF);
    avs_byteenable <= 4'hF;
    for (int i = 0; i < 16; i++) begin
      port_pins_in <= 8'($urandom);
      bus(1'b1, 4'h4, 32'(i));
      check("pins", 32'(port_map), {22'h0, an_tab[i], vpos_tab[i], vneg_tab[i]});
      check("port_rd", 32'(port_read_data), 32'(port_pins_in & ~an_tab[i]));
    end
    // only the eight implemented channels are ever chosen
    for (int i = 0; i < 8; i++) begin
      conv(3'(i), 1'(i), 3'($urandom), 1'b0);
    end
    conv(3'b011, 1'b1, 3'h5, 1'b1);
    trig(1'b0);
    trig(1'b1);
    bus(1'b1, 4'h0, 32'h185);
    bus(1'b1, 4'h8, 32'h0);
    rd_chk("kept", 4'hC, {24'h0, levels[7:0]});
    kept = q;
    repeat (100) @(posedge ref_clk);
    bus(1'b1, 4'h0, 32'h81);
    repeat (200) @(posedge ref_clk);
    rd_chk("abort", 4'h0, 32'h81);
    rd_chk("abort_res", 4'hC, kept);
    check("resample", 32'(sample_connect), 32'h1);
    sleep_mode <= 1'b1;
    bus(1'b1, 4'h0, 32'h85);
    repeat (500) @(posedge ref_clk);
    rd_chk("sleep_hold", 4'h0, 32'h85);
    sleep_mode <= 1'b0;
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    rd_chk("rst_main", 4'h0, 32'h0);
    check("rst_off", 32'(converter_powered), 32'h0);
    rd_chk("rst_res", 4'hC, kept);
    end_of_test();
  end
endmodule
